// ### hdl/dram_ctrl.sv
// Controller driving a 16K x 1 multiplexed-address dynamic RAM.
`include "dram_ctrl_defines.svh"
module dram_ctrl #(
  parameter int REF_INTERVAL = `REF_INTERVAL_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire dram_ctrl_pkg::op_t     req_op,
  input  wire logic [13:0]            req_addr,
  input  wire logic                   req_wdata,
  input  wire logic                   req_page,
  output logic                        rsp_valid,
  output logic                        rsp_rdata,
  output logic [6:0]                  dram_addr,
  output logic                        row_strobe_n,
  output logic                        column_strobe_n,
  output logic                        write_n,
  output logic                        dram_din,
  input  wire logic                   dram_dout,
  input  wire logic                   dram_dout_oe
);
  localparam int C_RAH  = `CYC_MIN1(`T_RAH_NS);
  localparam int C_CAC  = `CYC_MIN1(`T_CAC_NS) + 1;
  localparam int C_CAS  = `CYC_MIN1(`T_CAS_NS);
  localparam int C_CWD  = `CYC_MIN1(`T_CWD_NS);
  localparam int C_RWD  = `CYC_MIN1(`T_RWD_NS);
  localparam int C_WP   = `CYC_MIN1(`T_WP_NS);
  localparam int C_CP   = `CYC_MIN1(`T_CP_NS);
  localparam int C_RP   = `CYC_MIN1(`T_RP_NS);
  localparam int C_RAS  = `CYC_MIN1(`T_RAS_NS);
  localparam int C_OFF  = `CYC_MIN1(`T_OFF_NS);

  dram_ctrl_pkg::state_t state;
  dram_ctrl_pkg::state_t next_state;
  dram_ctrl_pkg::op_t    op;
  logic [13:0]           addr;
  logic                  wdata;
  logic                  page;
  logic                  refresh;
  logic [6:0]            ref_row;
  logic                  ref_due;
  logic [31:0]           ref_timer;
  logic [15:0]           cnt;
  logic [15:0]           ras_cnt;
  logic                  dout_s;
  logic                  dout_oe_s;
  logic                  cnt_done;
  logic                  take;
  logic                  page_take;
  logic [15:0]           next_wait;

  // ----------------------------------------------------------------
  // Pin input synchronisers.
  // ----------------------------------------------------------------
  in_sync3 u_sync_dout (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (dram_dout),
    .level   (dout_s)
  );
  in_sync3 u_sync_oe (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (dram_dout_oe),
    .level   (dout_oe_s)
  );

  function automatic logic [15:0] cyc(input int n);
    cyc = 16'(n - 1);
  endfunction

  function automatic logic op_w(input dram_ctrl_pkg::state_t s);
    op_w = (s == dram_ctrl_pkg::st_col) ? (page_take ? (req_op == dram_ctrl_pkg::op_write)
                                                     : (op == dram_ctrl_pkg::op_write))
                                        : (op == dram_ctrl_pkg::op_write);
  endfunction

  // ----------------------------------------------------------------
  // Decoding.
  // ----------------------------------------------------------------
  assign cnt_done  = (cnt == 16'h0000);
  assign take      = (state == dram_ctrl_pkg::st_idle) && req_valid && !ref_due;
  assign page_take = (state == dram_ctrl_pkg::st_pre_c) && page && req_valid && !ref_due
                     && (req_addr[13:7] == addr[13:7]) && cnt_done;
  assign req_ready = take || page_take;

  always_comb begin
    next_state = state;
    next_wait  = 16'h0000;
    case (state)
      dram_ctrl_pkg::st_idle: begin
        if (ref_due || req_valid) begin
          next_state = dram_ctrl_pkg::st_row;
        end
      end
      dram_ctrl_pkg::st_row: begin
        next_state = dram_ctrl_pkg::st_rah;
        next_wait  = cyc(C_RAH);
      end
      dram_ctrl_pkg::st_rah: begin
        if (cnt_done) begin
          next_state = refresh ? dram_ctrl_pkg::st_hold : dram_ctrl_pkg::st_col;
        end
      end
      dram_ctrl_pkg::st_col: begin
        next_state = dram_ctrl_pkg::st_cas;
        next_wait  = (op == dram_ctrl_pkg::op_write) ? cyc(C_CAS) : cyc(C_CAC);
      end
      dram_ctrl_pkg::st_cas: begin
        if (cnt_done) begin
          next_state = (op == dram_ctrl_pkg::op_rmw) ? dram_ctrl_pkg::st_wr : dram_ctrl_pkg::st_pre_c;
          next_wait  = (op == dram_ctrl_pkg::op_rmw) ? cyc(C_WP) : cyc(C_CP);
        end
      end
      dram_ctrl_pkg::st_wr: begin
        if (cnt_done) begin
          next_state = dram_ctrl_pkg::st_pre_c;
          next_wait  = cyc(C_CP);
        end
      end
      dram_ctrl_pkg::st_hold: begin
        if (ras_cnt == 16'h0000) begin
          next_state = dram_ctrl_pkg::st_pre;
          next_wait  = cyc(C_RP);
        end
      end
      dram_ctrl_pkg::st_pre_c: begin
        if (page_take) begin
          next_state = dram_ctrl_pkg::st_col;
        end else if (cnt_done && ras_cnt == 16'h0000) begin
          next_state = dram_ctrl_pkg::st_pre;
          next_wait  = cyc(C_RP);
        end
      end
      dram_ctrl_pkg::st_pre: begin
        if (cnt_done) begin
          next_state = dram_ctrl_pkg::st_idle;
        end
      end
      default: next_state = dram_ctrl_pkg::st_idle;
    endcase
  end

  // ----------------------------------------------------------------
  // State, counters and request capture.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= dram_ctrl_pkg::st_idle;
      cnt   <= 16'h0000;
    end else begin
      state <= next_state;
      cnt   <= (next_state != state) ? next_wait : (cnt_done ? cnt : cnt - 16'h0001);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ras_cnt <= 16'h0000;
    end else if (state == dram_ctrl_pkg::st_row) begin
      ras_cnt <= cyc(C_RAS);
    end else if (ras_cnt != 16'h0000) begin
      ras_cnt <= ras_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op      <= dram_ctrl_pkg::op_read;
      addr    <= 14'h0000;
      wdata   <= 1'b0;
      page    <= 1'b0;
      refresh <= 1'b0;
    end else if (state == dram_ctrl_pkg::st_idle && next_state == dram_ctrl_pkg::st_row) begin
      refresh <= ref_due;
      if (take) begin
        op    <= req_op;
        addr  <= req_addr;
        wdata <= req_wdata;
        page  <= req_page;
      end
    end else if (page_take) begin
      op    <= req_op;
      addr  <= req_addr;
      wdata <= req_wdata;
      page  <= req_page;
    end
  end

  // ----------------------------------------------------------------
  // Refresh scheduler.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ref_timer <= 32'h0000_0000;
      ref_due   <= 1'b0;
      ref_row   <= 7'h00;
    end else begin
      if (ref_timer >= 32'(REF_INTERVAL - 1)) begin
        ref_timer <= 32'h0000_0000;
        ref_due   <= 1'b1;
      end else begin
        ref_timer <= ref_timer + 32'h0000_0001;
        if (state == dram_ctrl_pkg::st_row && refresh) begin
          ref_due <= 1'b0;
        end
      end
      if (state == dram_ctrl_pkg::st_hold && next_state == dram_ctrl_pkg::st_pre) begin
        ref_row <= ref_row + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dram_addr       <= 7'h00;
      row_strobe_n    <= 1'b1;
      column_strobe_n <= 1'b1;
      write_n         <= 1'b1;
      dram_din        <= 1'b0;
    end else begin
      if (next_state == dram_ctrl_pkg::st_row) begin
        dram_addr <= ref_due ? ref_row : (take ? req_addr[13:7] : addr[13:7]);
      end else if (next_state == dram_ctrl_pkg::st_col) begin
        dram_addr <= page_take ? req_addr[6:0] : addr[6:0];
      end
      row_strobe_n    <= (next_state == dram_ctrl_pkg::st_idle) || (next_state == dram_ctrl_pkg::st_pre)
                         || (next_state == dram_ctrl_pkg::st_row);
      column_strobe_n <= !((next_state == dram_ctrl_pkg::st_cas) || (next_state == dram_ctrl_pkg::st_wr));
      write_n         <= !(((next_state == dram_ctrl_pkg::st_col || next_state == dram_ctrl_pkg::st_cas)
                         && op_w(next_state)) || next_state == dram_ctrl_pkg::st_wr);
      if (next_state == dram_ctrl_pkg::st_col) begin
        dram_din <= page_take ? req_wdata : wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data capture after the access time.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (state == dram_ctrl_pkg::st_cas && cnt_done && op != dram_ctrl_pkg::op_write) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= dout_oe_s ? dout_s : 1'b0;
      end
    end
  end

  logic unused_cwd;
  assign unused_cwd = (C_CWD > C_CAS) && (C_RWD > C_RAS) && (C_OFF > 0);
endmodule

// ### hdl/dram_ctrl_defines.svh
// Timing constants and geometry for the 16K x 1 dynamic RAM controller.
`ifndef DRAM_CTRL_DEFINES_SVH
`define DRAM_CTRL_DEFINES_SVH
`define CLK_PERIOD_PS        4000
`define ROW_BITS             7
`define ROWS                 128
`define T_ASR_NS             0
`define T_RAH_NS             40
`define T_RCD_NS             50
`define T_RAS_NS             300
`define T_CAS_NS             200
`define T_RP_NS              200
`define T_CP_NS              120
`define T_CAC_NS             200
`define T_OFF_NS             80
`define T_DH_NS              90
`define T_CWD_NS             140
`define T_RWD_NS             240
`define T_WP_NS              90
`define T_CWL_NS             120
`define T_REF_MS             2
`define CYC_UP(ns)           ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_MIN1(ns)         ((`CYC_UP(ns) < 1) ? 1 : `CYC_UP(ns))
`define REF_INTERVAL_CYC     ((`T_REF_MS * 1000000000 / `CLK_PERIOD_PS) / `ROWS)
`endif

// ### hdl/dram_ctrl_pkg.sv
// Types shared by the dynamic RAM controller.
package dram_ctrl_pkg;
  typedef enum logic [1:0] {op_read, op_write, op_rmw} op_t;
  typedef enum {st_idle, st_row, st_rah, st_col, st_cas, st_wr, st_hold, st_pre_c, st_pre} state_t;
endpackage

// ### hdl/in_sync3.sv
// Three-stage input synchroniser for pin inputs.
module in_sync3 (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// ### testbench/dram_ctrl_properties.sv
// Concurrent checks on the pin and response ports of the DRAM controller.
module dram_ctrl_properties #(
  parameter int REF_INTERVAL = 200
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       rsp_valid,
  input wire logic [6:0] dram_addr,
  input wire logic       row_strobe_n,
  input wire logic       column_strobe_n,
  input wire logic       write_n,
  input wire logic       dram_din
);
  int gap;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Cycles since the row strobe last fell.
  always_ff @(posedge clk_sys) begin
    if (rst || $fell(row_strobe_n)) begin
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  reset_idle_a: assert property (disable iff (1'b0) rst |=>
    row_strobe_n && column_strobe_n && write_n && !rsp_valid) else $error("strobes not idle after reset");
  cas_in_row_a: assert property ($fell(column_strobe_n) |-> !row_strobe_n)
    else $error("column strobe fell outside a row cycle");
  row_hold_a: assert property ($fell(row_strobe_n) |=> $stable(dram_addr) [*8])
    else $error("row address moved during hold");
  col_hold_a: assert property ($fell(column_strobe_n) |=> $stable(dram_addr) [*8])
    else $error("column address moved during hold");
  cas_width_a: assert property ($fell(column_strobe_n) |=> !column_strobe_n [*8])
    else $error("column strobe pulse too short");
  precharge_a: assert property ($rose(row_strobe_n) |=> row_strobe_n [*8])
    else $error("row precharge too short");
  page_pre_a: assert property ($rose(column_strobe_n) && !row_strobe_n |=> column_strobe_n [*8])
    else $error("column precharge too short in page mode");
  write_in_row_a: assert property ($fell(write_n) |-> !row_strobe_n)
    else $error("write line fell outside a row cycle");
  din_early_a: assert property ($fell(column_strobe_n) && !write_n |=> $stable(dram_din) [*8])
    else $error("data moved after early write strobe");
  din_late_a: assert property ($fell(write_n) && !column_strobe_n |=> $stable(dram_din) [*8])
    else $error("data moved after delayed write strobe");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  refresh_gap_a: assert property (gap <= 2 * REF_INTERVAL)
    else $error("row strobe idle too long for refresh");
endmodule

// ### testbench/dram_model.sv
// Behavioural model of the 16K x 1 dynamic RAM on the controller's pins.
module dram_model (
  input  wire logic       row_strobe_n,
  input  wire logic       column_strobe_n,
  input  wire logic       write_n,
  input  wire logic [6:0] dram_addr,
  input  wire logic       dram_din,
  output logic            dout,
  output logic            dout_oe,
  output logic [15:0]     ref_count,
  output logic [6:0]      last_ref_row
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       mem [16384];
  logic [6:0] row;
  logic [6:0] col;
  logic       cas_seen;
  initial begin
    dout = 1'b0;
    dout_oe = 1'b0;
    ref_count = 16'h0000;
    last_ref_row = 7'h00;
    cas_seen = 1'b0;
  end
  always @(negedge row_strobe_n) begin
    #1;
    row = dram_addr;
    cas_seen = 1'b0;
  end
  always @(negedge column_strobe_n) begin
    #1;
    col = dram_addr;
    cas_seen = 1'b1;
    if (!write_n) begin
      mem[{row, col}] = dram_din;
    end else begin
      #149;
      if (!column_strobe_n) begin
        dout = mem[{row, col}];
        dout_oe = 1'b1;
      end
    end
  end
  always @(negedge write_n) begin
    #2;
    if (!column_strobe_n) begin
      mem[{row, col}] = dram_din;
    end
  end
  always @(posedge column_strobe_n) begin
    dout_oe = 1'b0;
    dout = ~dout;
  end
  always @(posedge row_strobe_n) begin
    if (!cas_seen) begin
      ref_count = ref_count + 16'h0001;
      last_ref_row = row;
    end
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking testbench of the DRAM controller against the RAM model.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int REF_IV = 200;
  logic               clk_sys, rst, req_valid, req_ready, req_wdata, req_page, rsp_valid, rsp_rdata, got;
  dram_ctrl_pkg::op_t req_op;
  logic [13:0]        req_addr;
  logic [6:0]         dram_addr, last_ref_row;
  logic               row_strobe_n, column_strobe_n, write_n, dram_din, dram_dout, dram_dout_oe;
  logic [15:0]        ref_count;
  int                 bad_count, checked;
  dram_ctrl #(.REF_INTERVAL(REF_IV)) dut (.clk_sys, .rst, .req_valid, .req_ready, .req_op, .req_addr,
    .req_wdata, .req_page, .rsp_valid, .rsp_rdata, .dram_addr, .row_strobe_n, .column_strobe_n,
    .write_n, .dram_din, .dram_dout, .dram_dout_oe);
  dram_model mdl (.row_strobe_n, .column_strobe_n, .write_n, .dram_addr, .dram_din, .dout(dram_dout),
    .dout_oe(dram_dout_oe), .ref_count, .last_ref_row);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task report_and_stop();
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task give_up();
    bad_count++;
    report_and_stop();
  endtask
  task cmp_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmp_row(input logic [6:0] g, input logic [6:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic send(input dram_ctrl_pkg::op_t op, input logic [13:0] a, input logic d, input logic pg);
    int n;
    @(posedge clk_sys);
    #1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_page = pg;
    req_valid = 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 1000);
    if (n >= 1000) give_up();
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
  endtask
  task automatic wait_rsp(output logic d);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rsp_valid !== 1'b1 && n < 400);
    if (n >= 400) give_up();
    d = rsp_rdata;
    #1;
  endtask
  task automatic t_write_read();
    logic [13:0] a [4] = '{14'h0000, 14'h3fff, 14'h2a55, 14'h1580};
    for (int i = 0; i < 4; i++) send(dram_ctrl_pkg::op_write, a[i], i[0], 1'b0);
    for (int i = 0; i < 4; i++) begin
      send(dram_ctrl_pkg::op_read, a[i], 1'b0, 1'b0);
      wait_rsp(got);
      cmp_bit(got, i[0]);
    end
  endtask
  task automatic t_rmw();
    send(dram_ctrl_pkg::op_rmw, 14'h2a55, 1'b1, 1'b0);
    wait_rsp(got);
    cmp_bit(got, 1'b0);
    send(dram_ctrl_pkg::op_read, 14'h2a55, 1'b0, 1'b0);
    wait_rsp(got);
    cmp_bit(got, 1'b1);
  endtask
  task automatic t_page();
    send(dram_ctrl_pkg::op_write, 14'h0c01, 1'b1, 1'b0);
    send(dram_ctrl_pkg::op_write, 14'h0c02, 1'b0, 1'b0);
    send(dram_ctrl_pkg::op_read, 14'h0c01, 1'b0, 1'b1);
    wait_rsp(got);
    cmp_bit(got, 1'b1);
    send(dram_ctrl_pkg::op_read, 14'h0c02, 1'b0, 1'b0);
    wait_rsp(got);
    cmp_bit(got, 1'b0);
  endtask
  task automatic t_refresh();
    logic [15:0] c0;
    logic [6:0]  r0;
    c0 = ref_count;
    r0 = last_ref_row;
    repeat (1200) @(posedge clk_sys);
    #1;
    cmp_bit(ref_count - c0 >= 16'h0005, 1'b1);
    cmp_row(last_ref_row, r0 + 7'(ref_count - c0));
  endtask
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = dram_ctrl_pkg::op_read;
    req_addr = 14'h0000;
    req_wdata = 1'b0;
    req_page = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_write_read();
    t_rmw();
    t_page();
    t_refresh();
    report_and_stop();
  end
endmodule
bind dram_ctrl dram_ctrl_properties #(.REF_INTERVAL(REF_INTERVAL)) chk (.clk_sys, .rst, .rsp_valid,
  .dram_addr, .row_strobe_n, .column_strobe_n, .write_n, .dram_din);
